// >>> rtl/cfg_pkg.sv
/*
  shared constants of the converter configuration front end.
  assumes a 100 MHz system clock; the other files also write several of these numbers as literals.
*/
package cfg_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          RST_PULSE_NS   = 10;
  localparam int          RST_PULSE_CYC  =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SCLK_MAX_MHZ   = 20;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int          WORD_BITS      = 16;
  localparam int          ADDR_BITS      = 8;
  localparam int          DATA_BITS      = 8;
  localparam logic [3:0]  LAST_BIT       = 4'hf;

  // ----------------------------------------------------------------
  // register 0 (reset_control)
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_CONTROL_ADDR  = 8'h00;
  localparam logic [7:0]  RESET_CONTROL_RESET = 8'h00;
  localparam int          SOFT_RESET_BIT      = 7;
  localparam int          READOUT_BIT         = 0;

  // ----------------------------------------------------------------
  // format select pin levels and sample path
  // ----------------------------------------------------------------
  localparam logic [1:0]  FMT_LVL_GND    = 2'h0;
  localparam logic [1:0]  FMT_LVL_3_8    = 2'h1;
  localparam logic [1:0]  FMT_LVL_5_8    = 2'h2;
  localparam logic [1:0]  FMT_LVL_FULL   = 2'h3;
  localparam int          SAMPLE_BITS    = 14;
  localparam int          PAIR_LANES     = SAMPLE_BITS / 2;
endpackage

// >>> rtl/pin_sync.sv
/*
  three-flop synchroniser with agreement filter for one pin input.
  assumes the pin is asynchronous to clk; output changes only when the
  second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage_q;
  logic       level_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= {3{RESET_VAL}};
      level_q <= RESET_VAL;
    end else begin
      stage_q <= {stage_q[1:0], pin};
      if (stage_q[1] == stage_q[2]) begin
        level_q <= stage_q[2];
      end
    end
  end

  assign level = level_q;
endmodule

// >>> rtl/adc_serial_config_port.sv
/*
  configuration front end: three-wire serial write port, register 0,
  hardware and software reset, format select, output gate, standby and
  the sample word output formatting.
  assumes all pins are asynchronous to clk and the shift clock stays
  at or below 20 MHz so every level lasts several system clocks.
*/
//
// Behaviour
// - shift only while select is low
// - sample data on shift clock falling edge
// - commit word on every sixteenth edge
// - drop trailing bits short of a word
// - several words per select period allowed
// - address byte first, then data byte
// - any shift rate up to 20MHz
// - reset pin high pulse restores defaults
// - soft reset bit loads defaults, self-clears
// - four-level pin picks format and interface
// - output gate pin enables data buffers
// - data pin controls standby when port unused
// - late output clock adds one word period (two clocks) latency
// - ddr lanes carry even then odd bit
// - cmos pins carry one bit each
// - readout mode blocks writes except register 0
`timescale 1ns/1ps
module adc_serial_config_port (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  // serial configuration pins
  input  wire logic                           serial_select_n,
  input  wire logic                           shift_clock,
  input  wire logic                           serial_in_line,
  input  wire logic                           reset_pin,
  // parallel control pins
  input  wire logic [1:0]                     format_select_pin,
  input  wire logic                           output_gate_pin,
  // sample path
  input  wire logic [cfg_pkg::SAMPLE_BITS-1:0] sample_word,
  input  wire logic                           late_output_clock,
  // register write port toward the rest of the register map
  output logic                                reg_write,
  output logic [cfg_pkg::ADDR_BITS-1:0]       reg_addr,
  output logic [cfg_pkg::DATA_BITS-1:0]       reg_data,
  output logic                                regs_to_default,
  // register 0 and mode state
  output logic [cfg_pkg::DATA_BITS-1:0]       reset_control,
  output logic                                readout_mode,
  output logic                                offset_binary,
  output logic                                cmos_mode,
  output logic                                buffers_enabled,
  output logic                                standby,
  // formatted output data
  output logic [cfg_pkg::SAMPLE_BITS-1:0]     cmos_data,
  output logic [cfg_pkg::PAIR_LANES-1:0]      ddr_data,
  output logic                                output_strobe
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_lvl;

  // stages reset low, the idle level of the shift clock, so no false
  // falling edge follows reset
  assign pin_raw = {format_select_pin, output_gate_pin, reset_pin,
                    serial_in_line, shift_clock};

  for (genvar i = 0; i < 6; i++) begin : g_sync
    pin_sync #(
      .RESET_VAL (1'b0)
    ) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .pin    (pin_raw[i]),
      .level  (pin_lvl[i])
    );
  end

  logic select_lvl_n;
  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_select_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (serial_select_n),
    .level  (select_lvl_n)
  );

  wire       sclk_lvl   = pin_lvl[0];
  wire       data_lvl   = pin_lvl[1];
  wire       rst_lvl    = pin_lvl[2];
  wire       gate_lvl   = pin_lvl[3];
  wire [1:0] fmt_lvl    = pin_lvl[5:4];

  // ----------------------------------------------------------------
  // hardware reset pulse
  // ----------------------------------------------------------------
  logic [1:0] rst_cnt_q;
  // count saturates while high, so a long or tied-high level loads
  // defaults once; a low level rearms it for the next pulse
  wire  [1:0] rst_cnt_inc = (rst_cnt_q == 2'h3) ? rst_cnt_q
                                                : rst_cnt_q + 2'h1;
  wire  [1:0] rst_cnt_d   = rst_lvl ? rst_cnt_inc : 2'h0;
  wire        hw_reset    = rst_lvl &&
    (rst_cnt_q == 2'(cfg_pkg::RST_PULSE_CYC - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt_q  <= 2'h0;
    end else begin
      rst_cnt_q  <= rst_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic                          sclk_prev_q;
  logic [3:0]                    bit_cnt_q;
  logic [cfg_pkg::WORD_BITS-1:0] shift_q;

  wire sclk_fall  = sclk_prev_q && !sclk_lvl;
  wire shift_en   = sclk_fall && !select_lvl_n;
  wire word_done  = shift_en && (bit_cnt_q == cfg_pkg::LAST_BIT);
  wire [cfg_pkg::WORD_BITS-1:0] word_d = {shift_q[14:0], data_lvl};
  wire [7:0] w_addr = word_d[15:8];
  wire [7:0] w_data = word_d[7:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 16'h0000;
    end else begin
      sclk_prev_q <= sclk_lvl;
      if (select_lvl_n) begin
        bit_cnt_q <= 4'h0;
      end else if (shift_en) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= word_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // register 0 and write port
  // ----------------------------------------------------------------
  logic [7:0] reset_control_q;
  logic       reg_write_q;
  logic [7:0] reg_addr_q;
  logic [7:0] reg_data_q;
  logic       to_default_q;

  wire is_reg0   = (w_addr == cfg_pkg::RESET_CONTROL_ADDR);
  wire in_readout = reset_control_q[cfg_pkg::READOUT_BIT];
  wire write_ok  = word_done && (is_reg0 || !in_readout);
  wire soft_rst  = word_done && is_reg0 &&
                   w_data[cfg_pkg::SOFT_RESET_BIT];
  wire defaults  = hw_reset || soft_rst;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_control_q <= cfg_pkg::RESET_CONTROL_RESET;
      reg_write_q     <= 1'b0;
      reg_addr_q      <= 8'h00;
      reg_data_q      <= 8'h00;
      to_default_q    <= 1'b0;
    end else begin
      to_default_q <= defaults;
      reg_write_q  <= write_ok && !defaults;
      if (defaults) begin
        reset_control_q <= cfg_pkg::RESET_CONTROL_RESET;
      end else if (write_ok && is_reg0) begin
        reset_control_q <= w_data;
      end
      if (write_ok) begin
        reg_addr_q <= w_addr;
        reg_data_q <= w_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // parallel pins and standby
  // ----------------------------------------------------------------
  logic offset_q;
  logic cmos_q;
  logic buf_en_q;
  logic standby_q;

  wire fmt_offset = (fmt_lvl == cfg_pkg::FMT_LVL_5_8) ||
                    (fmt_lvl == cfg_pkg::FMT_LVL_FULL);
  wire fmt_cmos   = (fmt_lvl == cfg_pkg::FMT_LVL_3_8) ||
                    (fmt_lvl == cfg_pkg::FMT_LVL_5_8);
  // port counts as unused when reset is held high, select idles high and shift clock idles low
  wire port_unused = rst_lvl && select_lvl_n && !sclk_lvl;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_q  <= 1'b0;
      cmos_q    <= 1'b0;
      buf_en_q  <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      offset_q  <= fmt_offset;
      cmos_q    <= fmt_cmos;
      buf_en_q  <= gate_lvl;
      standby_q <= port_unused && data_lvl;
    end
  end

  // ----------------------------------------------------------------
  // sample output formatting
  // ----------------------------------------------------------------
  logic [13:0] stage_q;
  logic [13:0] late_q;
  logic [13:0] cmos_q_data;
  logic [6:0]  ddr_q;
  logic        phase_q;
  logic        strobe_q;

  wire [13:0] fmt_word = {stage_q[13] ^ offset_q, stage_q[12:0]};
  wire [13:0] out_word = late_output_clock ? late_q : fmt_word;
  logic [6:0] even_bits;
  logic [6:0] odd_bits;
  always_comb begin
    for (int k = 0; k < cfg_pkg::PAIR_LANES; k++) begin
      even_bits[k] = out_word[2*k];
      odd_bits[k]  = out_word[2*k+1];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q     <= 14'h0000;
      late_q      <= 14'h0000;
      cmos_q_data <= 14'h0000;
      ddr_q       <= 7'h00;
      phase_q     <= 1'b0;
      strobe_q    <= 1'b0;
    end else begin
      phase_q  <= ~phase_q;
      strobe_q <= buf_en_q && !phase_q;
      if (!phase_q) begin
        stage_q <= sample_word;
        late_q  <= fmt_word;
      end
      cmos_q_data <= (buf_en_q && cmos_q) ? out_word : 14'h0000;
      if (buf_en_q && !cmos_q) begin
        ddr_q <= phase_q ? odd_bits : even_bits;
      end else begin
        ddr_q <= 7'h00;
      end
    end
  end

  assign reg_write       = reg_write_q;
  assign reg_addr        = reg_addr_q;
  assign reg_data        = reg_data_q;
  assign regs_to_default = to_default_q;
  assign reset_control   = reset_control_q;
  assign readout_mode    = reset_control_q[cfg_pkg::READOUT_BIT];
  assign offset_binary   = offset_q;
  assign cmos_mode       = cmos_q;
  assign buffers_enabled = buf_en_q;
  assign standby         = standby_q;
  assign cmos_data       = cmos_q_data;
  assign ddr_data        = ddr_q;
  assign output_strobe   = strobe_q;
endmodule

// >>> verif/cfg_port_chk.sv
/*
  assertions on the ports of the configuration front end.
  assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cfg_port_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // watched outputs
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic        regs_to_default,
  input wire logic [7:0]  reset_control,
  input wire logic        readout_mode,
  input wire logic        cmos_mode,
  input wire logic        buffers_enabled,
  input wire logic [13:0] cmos_data,
  input wire logic [6:0]  ddr_data,
  input wire logic        output_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  a_write_one_pulse: assert property (reg_write |=> !reg_write)
    else $error("write strobe wider than one cycle");
  a_default_one_pulse: assert property (
    regs_to_default |=> !regs_to_default)
    else $error("default strobe wider than one cycle");
  a_default_no_write: assert property (
    regs_to_default |-> !reg_write)
    else $error("write strobe during default load");
  a_soft_bit_clear: assert property (!reset_control[7])
    else $error("soft reset bit stored");
  a_readout_mirror: assert property (
    readout_mode == reset_control[0])
    else $error("readout flag differs from register");
  a_readout_block: assert property (
    reg_write && $past(readout_mode) |-> reg_addr == 8'h00)
    else $error("write accepted in readout mode");
  a_reg0_source: assert property ($changed(reset_control) |->
    (reg_write && reg_addr == 8'h00) || regs_to_default
    || $past(regs_to_default))
    else $error("register 0 changed without cause");
  // ---------------------------------------------------------------
  // output path
  // ---------------------------------------------------------------
  a_cmos_lanes_idle: assert property (
    cmos_mode [*3] |-> ddr_data == 7'h00)
    else $error("ddr lanes active in cmos mode");
  a_lvds_pins_idle: assert property (
    (!cmos_mode) [*3] |-> cmos_data == 14'h0000)
    else $error("cmos pins active in ddr mode");
  a_gate_quiet: assert property ((!buffers_enabled) [*3] |->
    cmos_data == 14'h0000 && ddr_data == 7'h00 && !output_strobe)
    else $error("outputs active with buffers off");
  c_readout_write: cover property (reg_write && readout_mode);
  c_default: cover property (regs_to_default);
  c_strobe: cover property (output_strobe && !cmos_mode);
endmodule
bind adc_serial_config_port cfg_port_chk cfg_port_chk_inst (
  .clk, .arst_n, .reg_write, .reg_addr, .regs_to_default,
  .reset_control, .readout_mode, .cmos_mode, .buffers_enabled,
  .cmos_data, .ddr_data, .output_strobe);

// >>> verif/serial_ctrl.sv
/*
  behavioural configuration controller driving the three serial pins.
  assumes the system clock only paces it; shift clock runs in frames.
*/
`timescale 1ns/1ps
module serial_ctrl (
  // pacing clock
  input wire logic clk,
  // serial pins
  output logic     serial_select_n,
  output logic     shift_clock,
  output logic     serial_in_line
);
  initial begin
    serial_select_n = 1'b1;
    shift_clock = 1'b0;
    serial_in_line = 1'b0;
  end
  task automatic pace(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one select period; bits sent msb first, address byte leads
  task automatic send(input logic [47:0] bits, input int n);
    pace(1);
    serial_select_n = 1'b0;
    pace(5);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = bits[i];
      pace(4);
      // uneven duty: 40 ns high, 70 ns low; data held past the fall
      shift_clock = 1'b1;
      pace(4);
      shift_clock = 1'b0;
      pace(3);
    end
    pace(5);
    serial_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    pace(10);
  endtask
  // port unused: pins parked, data pin used as a level
  task automatic park(input logic v);
    serial_select_n = 1'b1;
    shift_clock = 1'b0;
    serial_in_line = v;
  endtask
endmodule

// >>> verif/tb_top.sv
/*
  self-checking bench for the configuration front end.
  assumes the serial_ctrl model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, arst_n = 0, reset_pin = 0, output_gate_pin = 0;
  logic late_output_clock = 0;
  logic [1:0] format_select_pin = 2'h0;
  logic [13:0] sample_word = 14'h0000, cmos_data;
  logic serial_select_n, shift_clock, serial_in_line, reg_write;
  logic regs_to_default, readout_mode, offset_binary, cmos_mode;
  logic buffers_enabled, standby, output_strobe;
  logic [7:0] reg_addr, reg_data, reset_control;
  logic [6:0] ddr_data, ev, od;
  logic [15:0] wq[$];
  int mismatches = 0, tests_run = 0, ndef = 0, cyc = 0, w;
  int lat[2];
  always #5 clk = ~clk;
  serial_ctrl serial_ctrl_inst (.clk, .serial_select_n, .shift_clock,
    .serial_in_line);
  adc_serial_config_port adc_serial_config_port_inst (.clk, .arst_n,
    .serial_select_n, .shift_clock, .serial_in_line, .reset_pin,
    .format_select_pin, .output_gate_pin, .sample_word,
    .late_output_clock, .reg_write, .reg_addr, .reg_data,
    .regs_to_default, .reset_control, .readout_mode, .offset_binary,
    .cmos_mode, .buffers_enabled, .standby, .cmos_data, .ddr_data,
    .output_strobe);
  always @(posedge clk) begin
    if (reg_write === 1'b1) wq.push_back({reg_addr, reg_data});
    if (regs_to_default === 1'b1) ndef++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic seen(input logic [15:0] e);
    chk("word", wq.pop_front(), e);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    step(20);
    arst_n = 1;
    step(10);
    reset_pin = 1;
    step(5);
    reset_pin = 0;
    step(10);
    chk("hw_default", ndef, 1);
    serial_ctrl_inst.send(48'h05a5_3c81, 32);
    seen(16'h05a5);
    seen(16'h3c81);
    serial_ctrl_inst.send(48'h1234f, 20);
    seen(16'h1234);
    serial_ctrl_inst.send(48'h77, 8);
    serial_ctrl_inst.send(48'h2299, 16);
    seen(16'h2299);
    serial_ctrl_inst.send(48'h0001, 16);
    seen(16'h0001);
    chk("readout_on", readout_mode, 1);
    serial_ctrl_inst.send(48'h0566, 16);
    serial_ctrl_inst.send(48'h0000, 16);
    seen(16'h0000);
    chk("readout_off", readout_mode, 0);
    serial_ctrl_inst.send(48'h0081, 16);
    chk("soft_default", ndef, 2);
    chk("reg0", reset_control, 16'h0000);
    chk("extra", wq.size(), 0);
    output_gate_pin = 1;
    sample_word = 14'h1abc;
    for (int k = 0; k < 7; k++) begin
      ev[k] = sample_word[2*k];
      od[k] = sample_word[2*k+1];
    end
    for (int i = 0; i < 4; i++) begin
      format_select_pin = i[1:0];
      step(12);
      chk("offset", offset_binary, i[1]);
      chk("cmos", cmos_mode, i[0] ^ i[1]);
      if (i[0] ^ i[1]) chk("cmos_data", cmos_data, {i[1], 13'h1abc});
      else begin
        w = 0;
        while (output_strobe !== 1'b1 && w < 10) begin
          step(1);
          w++;
        end
        chk("ddr_even", ddr_data, ev);
        step(1);
        chk("ddr_odd", ddr_data, od ^ {i[1], 6'h00});
      end
    end
    format_select_pin = 2'h1;
    // new sample latency, measured from the same word phase each time
    for (int j = 0; j < 2; j++) begin
      late_output_clock = j[0];
      sample_word = 14'h0abc;
      step(12);
      w = 0;
      while (output_strobe !== 1'b1 && w < 10) begin
        step(1);
        w++;
      end
      sample_word = 14'h1234;
      w = 0;
      while (cmos_data !== 14'h1234 && w < 20) begin
        step(1);
        w++;
      end
      lat[j] = w;
    end
    // one word period is two system clocks
    chk("late_latency", lat[1] - lat[0], 2);
    output_gate_pin = 0;
    step(12);
    chk("gated", cmos_data, 14'h0000);
    chk("buffers", buffers_enabled, 0);
    reset_pin = 1;
    late_output_clock = 1;
    serial_ctrl_inst.park(1'b1);
    step(12);
    chk("standby_on", standby, 1);
    chk("hw_default2", ndef, 3);
    serial_ctrl_inst.park(1'b0);
    step(12);
    chk("standby_off", standby, 0);
    end_sim();
  end
endmodule
